// *** design/pfr_engine.sv ***
// Flow-control state machine, refresh shadow counter and frame requests.
// Assumes occupancy and settings come from logic on the same clock.
`timescale 1ns/1ps
module pfr_engine
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Settings and live buffer occupancy in bytes.
  input wire pfr_pkg::pfr_cfg_t cfg,
  input wire logic [pfr_pkg::OCC_W-1:0] rx_occupancy,
  input wire logic [pfr_pkg::CNT_W-1:0] pause_time_value,
  // Frame request and its acceptance.
  output pfr_pkg::pfr_req_t tx_req,
  input wire logic tx_req_ready,
  // State shown to software.
  output pfr_pkg::pfr_stat_t stat
);

  // Whole state of the engine.
  typedef struct packed {
    pfr_pkg::pfr_fc_t fc_state;
    logic [pfr_pkg::CNT_W-1:0] cnt;
    pfr_pkg::pfr_req_t req;
  } pfr_eng_t;

  pfr_eng_t cur; // Registered state.
  pfr_eng_t next_cur; // Next state.
  logic [pfr_pkg::OCC_W-1:0] high_bytes; // High watermark in bytes.
  logic [pfr_pkg::OCC_W-1:0] low_bytes; // Low watermark in bytes.
  logic send_off; // Request an XOFF frame this cycle.
  logic send_on; // Request an XON frame this cycle.

  // Watermarks count 16-byte units, so append four zero bits.
  assign high_bytes = {cfg.high_watermark, {pfr_pkg::WM_LSB{1'b0}}};
  assign low_bytes = {1'b0, cfg.low_watermark, {pfr_pkg::WM_LSB{1'b0}}};

  // Next-state logic for the state machine, counter and request.
  always_comb
  begin
    next_cur = cur;
    send_off = 1'b0;
    send_on = 1'b0;
    // A pending request stays until the transmitter takes it.
    if (tx_req_ready)
    begin
      next_cur.req.valid = 1'b0;
    end
    unique case (cur.fc_state)
      pfr_pkg::FC_XON:
      begin
        if (cfg.tx_pause_enable && rx_occupancy >= high_bytes)
        begin
          send_off = 1'b1;
          next_cur.fc_state = pfr_pkg::FC_XOFF;
        end
      end
      pfr_pkg::FC_XOFF:
      begin
        if (!cfg.tx_pause_enable || rx_occupancy <= low_bytes)
        begin
          // Drained to or below low, or pausing was switched off.
          next_cur.fc_state = pfr_pkg::FC_XON;
          send_on = cfg.tx_pause_enable && cfg.resume_frame_enable;
        end
        else if (cfg.refresh_threshold_field != pfr_pkg::THR_RST &&
                 cur.cnt == cfg.refresh_threshold_field)
        begin
          send_off = 1'b1;
        end
      end
    endcase
    // Counter restarts on each XOFF sent and on return to XON.
    if (send_off || next_cur.fc_state == pfr_pkg::FC_XON)
    begin
      next_cur.cnt = pfr_pkg::CNT_RST;
    end
    else if (cur.cnt != {pfr_pkg::CNT_W{1'b1}})
    begin
      // Saturate rather than wrap, so a large threshold is not hit twice.
      next_cur.cnt = cur.cnt + 1'b1;
    end
    // A newer request replaces one that has not been taken yet.
    if (send_off || send_on)
    begin
      next_cur.req.valid = 1'b1;
      next_cur.req.is_resume = send_on;
      next_cur.req.pause_time = send_on ? pfr_pkg::XON_TIME
                                        : pause_time_value;
    end
  end

  // State register.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cur <= '{fc_state: pfr_pkg::FC_XON, cnt: pfr_pkg::CNT_RST,
               req: '{valid: 1'b0, is_resume: 1'b0,
                      pause_time: pfr_pkg::TIME_RST}};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Request and status outputs.
  assign tx_req = cur.req;
  assign stat.fc_state = cur.fc_state;
  assign stat.above_high = rx_occupancy > high_bytes;
  // Below-low includes equality, matching the XON drain test, so the
  // flag reads one straight after reset with occupancy and mark at zero.
  assign stat.below_low = rx_occupancy <= low_bytes;
  assign stat.refresh_count = cur.cnt;

endmodule : pfr_engine

// *** design/pfr_pkg.sv ***
// Shared constants and types for the pause refresh and status block.
// Assumes one 20 MHz core clock and an AHB-Lite register bus.
package pfr_pkg;

  // Byte addresses of the registers on the bus.
  localparam logic [15:0] OFF_REFRESH_THR = 16'h2460;
  localparam logic [15:0] OFF_STATUS = 16'h2464;
  localparam logic [15:0] OFF_CONTROL = 16'h2470;
  localparam logic [15:0] OFF_HIGH_WM = 16'h2474;
  localparam logic [15:0] OFF_LOW_WM = 16'h2478;
  localparam logic [15:0] OFF_PAUSE_TIME = 16'h247c;

  // Field positions inside the status word.
  localparam int ST_STATE_BIT = 0;
  localparam int ST_ABOVE_BIT = 1;
  localparam int ST_BELOW_BIT = 2;
  localparam int ST_CNT_LSB = 16;

  // Field positions inside the control word.
  localparam int CTL_TX_PAUSE_BIT = 0;
  localparam int CTL_RESUME_BIT = 1;

  // Watermark fields sit above four byte-granularity bits.
  localparam int WM_LSB = 4;
  localparam int HIGH_WM_MSB = 17;
  localparam int LOW_WM_MSB = 16;
  localparam int HIGH_WM_W = HIGH_WM_MSB - WM_LSB + 1;
  localparam int LOW_WM_W = LOW_WM_MSB - WM_LSB + 1;

  // Widths of the counter, threshold, pause time and occupancy.
  localparam int CNT_W = 16;
  localparam int OCC_W = 18;

  // Reset values.
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] THR_RST = 16'h0000;
  localparam logic [CNT_W-1:0] TIME_RST = 16'h0000;
  localparam logic [CNT_W-1:0] XON_TIME = 16'h0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // Register selected by an address.
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_THR = 3'b001,
    SEL_STATUS = 3'b010,
    SEL_CONTROL = 3'b011,
    SEL_HIGH = 3'b100,
    SEL_LOW = 3'b101,
    SEL_TIME = 3'b110
  } pfr_sel_t;

  // Flow-control state; the code is the status bit.
  typedef enum logic [0:0] {
    FC_XON = 1'b0,
    FC_XOFF = 1'b1
  } pfr_fc_t;

  // Settings handed from the register file to the engine.
  typedef struct packed {
    logic tx_pause_enable;
    logic resume_frame_enable;
    logic [HIGH_WM_W-1:0] high_watermark;
    logic [LOW_WM_W-1:0] low_watermark;
    logic [CNT_W-1:0] refresh_threshold_field;
  } pfr_cfg_t;

  // State reported back by the engine.
  typedef struct packed {
    pfr_fc_t fc_state;
    logic above_high;
    logic below_low;
    logic [CNT_W-1:0] refresh_count;
  } pfr_stat_t;

  // Pause frame request towards the transmitter.
  typedef struct packed {
    logic valid;
    logic is_resume;
    logic [CNT_W-1:0] pause_time;
  } pfr_req_t;

endpackage : pfr_pkg

// *** design/pfr_top.sv ***
// Pause refresh and status block: AHB-Lite register file plus engine.
// Assumes one bus master, word-wide single transfers, same-clock occupancy.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module pfr_top
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Receive buffer occupancy in bytes.
  input wire logic [pfr_pkg::OCC_W-1:0] rx_occupancy,
  // Pause frame request to the transmitter.
  output logic tx_req_valid,
  output logic tx_req_resume,
  output logic [pfr_pkg::CNT_W-1:0] tx_req_pause_time,
  input wire logic tx_req_ready
);

  // Whole state of the register file and bus slave.
  typedef struct packed {
    logic wr_pend;
    pfr_pkg::pfr_sel_t wr_sel;
    logic [31:0] rdata;
    pfr_pkg::pfr_cfg_t cfg;
    logic [pfr_pkg::CNT_W-1:0] pause_time_value;
  } pfr_regs_t;

  pfr_regs_t cur; // Registered state.
  pfr_regs_t next_cur; // Next state.
  pfr_pkg::pfr_stat_t stat; // Engine state for the status word.
  pfr_pkg::pfr_req_t req; // Engine frame request.
  pfr_pkg::pfr_sel_t addr_sel; // Register hit by the address phase.
  logic addr_take; // An address phase is accepted this cycle.

  // Map a byte address to a register; used for reads and writes.
  function automatic pfr_pkg::pfr_sel_t decode(input logic [31:0] addr);
    pfr_pkg::pfr_sel_t sel;
    sel = pfr_pkg::SEL_NONE;
    // Upper address bits are not decoded; the block aliases above them.
    unique case (addr[15:0])
      pfr_pkg::OFF_REFRESH_THR: sel = pfr_pkg::SEL_THR;
      pfr_pkg::OFF_STATUS: sel = pfr_pkg::SEL_STATUS;
      pfr_pkg::OFF_CONTROL: sel = pfr_pkg::SEL_CONTROL;
      pfr_pkg::OFF_HIGH_WM: sel = pfr_pkg::SEL_HIGH;
      pfr_pkg::OFF_LOW_WM: sel = pfr_pkg::SEL_LOW;
      pfr_pkg::OFF_PAUSE_TIME: sel = pfr_pkg::SEL_TIME;
      default: sel = pfr_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction : decode

  // Build the read word of one register from a given configuration.
  function automatic logic [31:0] read_word(
    input pfr_pkg::pfr_sel_t sel,
    input pfr_pkg::pfr_cfg_t cfg,
    input logic [pfr_pkg::CNT_W-1:0] ptime,
    input pfr_pkg::pfr_stat_t st
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (sel)
      pfr_pkg::SEL_THR:
      begin
        // Only the low half is stored; the upper half reads zero.
        w[pfr_pkg::CNT_W-1:0] = cfg.refresh_threshold_field;
      end
      pfr_pkg::SEL_STATUS:
      begin
        w[pfr_pkg::ST_STATE_BIT] = st.fc_state;
        w[pfr_pkg::ST_ABOVE_BIT] = st.above_high;
        w[pfr_pkg::ST_BELOW_BIT] = st.below_low;
        w[pfr_pkg::ST_CNT_LSB +: pfr_pkg::CNT_W] = st.refresh_count;
      end
      pfr_pkg::SEL_CONTROL:
      begin
        w[pfr_pkg::CTL_TX_PAUSE_BIT] = cfg.tx_pause_enable;
        w[pfr_pkg::CTL_RESUME_BIT] = cfg.resume_frame_enable;
      end
      pfr_pkg::SEL_HIGH:
      begin
        w[pfr_pkg::HIGH_WM_MSB:pfr_pkg::WM_LSB] = cfg.high_watermark;
      end
      pfr_pkg::SEL_LOW:
      begin
        w[pfr_pkg::LOW_WM_MSB:pfr_pkg::WM_LSB] = cfg.low_watermark;
      end
      pfr_pkg::SEL_TIME:
      begin
        w[pfr_pkg::CNT_W-1:0] = ptime;
      end
      default:
      begin
        // Unmapped addresses read as zero.
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction : read_word

  // Address phase is taken when selected, active and the bus is ready.
  assign addr_take = hsel && htrans[1] && hready;
  assign addr_sel = decode(haddr);

  // Next-state logic: finish a write's data phase, then look up reads.
  always_comb
  begin
    next_cur = cur;
    next_cur.wr_pend = 1'b0;
    // Data phase of a write: hwdata stands now, the address was held.
    if (cur.wr_pend)
    begin
      unique case (cur.wr_sel)
        pfr_pkg::SEL_THR:
        begin
          next_cur.cfg.refresh_threshold_field = hwdata[pfr_pkg::CNT_W-1:0];
        end
        pfr_pkg::SEL_CONTROL:
        begin
          next_cur.cfg.tx_pause_enable = hwdata[pfr_pkg::CTL_TX_PAUSE_BIT];
          next_cur.cfg.resume_frame_enable = hwdata[pfr_pkg::CTL_RESUME_BIT];
        end
        pfr_pkg::SEL_HIGH:
        begin
          next_cur.cfg.high_watermark =
            hwdata[pfr_pkg::HIGH_WM_MSB:pfr_pkg::WM_LSB];
        end
        pfr_pkg::SEL_LOW:
        begin
          next_cur.cfg.low_watermark =
            hwdata[pfr_pkg::LOW_WM_MSB:pfr_pkg::WM_LSB];
        end
        pfr_pkg::SEL_TIME:
        begin
          next_cur.pause_time_value = hwdata[pfr_pkg::CNT_W-1:0];
        end
        default:
        begin
          // Status writes and unmapped writes change nothing.
          next_cur.cfg = cur.cfg;
        end
      endcase
    end
    // Accept a new address phase.
    if (addr_take)
    begin
      next_cur.wr_pend = hwrite;
      next_cur.wr_sel = addr_sel;
      // Read data is built from the configuration as it will stand
      // after any write finishing now, so read-after-write is exact.
      next_cur.rdata = hwrite ? cur.rdata
        : read_word(addr_sel, next_cur.cfg, next_cur.pause_time_value,
                    stat);
    end
  end

  // State register; configuration resets to all disabled and zero.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cur <= '{wr_pend: 1'b0, wr_sel: pfr_pkg::SEL_NONE,
               rdata: pfr_pkg::RDATA_RST,
               cfg: '{tx_pause_enable: 1'b0, resume_frame_enable: 1'b0,
                      high_watermark: '0, low_watermark: '0,
                      refresh_threshold_field: pfr_pkg::THR_RST},
               pause_time_value: pfr_pkg::TIME_RST};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // The engine does the flow control itself.
  pfr_engine u_engine
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .cfg(cur.cfg),
    .rx_occupancy(rx_occupancy),
    .pause_time_value(cur.pause_time_value),
    .tx_req(req),
    .tx_req_ready(tx_req_ready),
    .stat(stat)
  );

  // The slave never stalls and never reports an error. The transfer
  // size is not checked: narrow accesses act as whole-word ones.
  assign hrdata = cur.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Frame request outputs, all from engine flip-flops.
  assign tx_req_valid = req.valid;
  assign tx_req_resume = req.is_resume;
  assign tx_req_pause_time = req.pause_time;

endmodule : pfr_top

// *** verification/pfr_top_bench.sv ***
// Self-checking bench for the pause refresh block over AHB-Lite.
// Assumes the transmitter model stands on the frame request port.
`timescale 1ns/1ps
module pfr_top_bench;
  // Byte addresses of the registers used here.
  localparam logic [31:0] A_THR = {16'h0000, pfr_pkg::OFF_REFRESH_THR};
  localparam logic [31:0] A_ST = {16'h0000, pfr_pkg::OFF_STATUS};
  localparam logic [31:0] A_CTL = {16'h0000, pfr_pkg::OFF_CONTROL};
  localparam logic [31:0] A_HI = {16'h0000, pfr_pkg::OFF_HIGH_WM};
  localparam logic [31:0] A_LO = {16'h0000, pfr_pkg::OFF_LOW_WM};
  localparam logic [31:0] A_PT = {16'h0000, pfr_pkg::OFF_PAUSE_TIME};
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [17:0] occ = 18'h00000;
  logic tx_req_valid;
  logic tx_req_resume;
  logic [15:0] tx_req_pause_time;
  logic tx_req_ready;
  logic [1:0] delay = 2'd3;
  logic [15:0] last_time;
  logic [31:0] q;
  int xoff_n;
  int xon_n;
  int n0;
  int fail_count = 0;
  int checks_done = 0;
  // The single slave's hreadyout is the bus hready.
  pfr_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_occupancy(occ),
    .tx_req_valid(tx_req_valid), .tx_req_resume(tx_req_resume),
    .tx_req_pause_time(tx_req_pause_time), .tx_req_ready(tx_req_ready));
  pfr_tx_model M (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .req_valid(tx_req_valid), .req_resume(tx_req_resume),
    .req_time(tx_req_pause_time), .delay(delay), .req_ready(tx_req_ready),
    .xoff_n(xoff_n), .xon_n(xon_n), .last_time(last_time));
  // A 50 ns clock.
  initial forever #25 sys_clk = ~sys_clk;
  // Ends the run with the counts and the verdict.
  task give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  // Compares a value seen with the value expected.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // One single transfer; read data lands in q at the data phase end.
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task rd_check(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask : rd_check
  // Cuts a hang short well past the expected few hundred cycles.
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    fail_count++;
    give_verdict;
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_check(A_ST, 32'h0000_0004);
    rd_check(A_THR, 32'h0000_0000);
    bus(1'b1, A_LO, 32'h0000_0030);
    rd_check(A_ST, 32'h0000_0004);
    bus(1'b1, A_ST, 32'hffff_ffff);
    rd_check(A_ST, 32'h0000_0004);
    rd_check(32'h0000_2480, 32'h0000_0000);
    $display("test reset and read-only done");
    bus(1'b1, A_HI, 32'h0000_0100);
    bus(1'b1, A_PT, 32'h0000_1234);
    bus(1'b1, A_CTL, 32'h0000_0001);
    occ <= 18'h00100;
    repeat (10) @(posedge sys_clk);
    check(xoff_n, 32'd1);
    check(last_time, 32'h0000_1234);
    bus(1'b0, A_ST, 32'h0000_0000);
    check(q[2:0], 32'h1);
    occ <= 18'h00101;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, A_ST, 32'h0000_0000);
    check(q[2:0], 32'h3);
    repeat (40) @(posedge sys_clk);
    check(xoff_n, 32'd1);
    $display("test pause entry done");
    delay <= 2'd0;
    bus(1'b1, A_THR, 32'h0000_0009);
    // The counter has already run past nine and will not wrap back, so drain
    // and refill to restart it; a resume frame is still disabled.
    occ <= 18'h00030;
    repeat (3) @(posedge sys_clk);
    rd_check(A_ST, 32'h0000_0004);
    n0 = xoff_n;
    occ <= 18'h00101;
    repeat (100) @(posedge sys_clk);
    check(xoff_n - n0 >= 9 && xoff_n - n0 <= 11, 32'd1);
    bus(1'b0, A_ST, 32'h0000_0000);
    check(q[31:16] <= 16'd9, 32'd1);
    occ <= 18'h00030;
    repeat (5) @(posedge sys_clk);
    n0 = xoff_n;
    repeat (50) @(posedge sys_clk);
    check(xoff_n, n0);
    check(xon_n, 32'd0);
    $display("test refresh done");
    // A resume frame needs a pass through pause first, so refill.
    bus(1'b1, A_CTL, 32'h0000_0003);
    occ <= 18'h00101;
    repeat (10) @(posedge sys_clk);
    occ <= 18'h00030;
    repeat (10) @(posedge sys_clk);
    check(xon_n, 32'd1);
    rd_check(A_ST, 32'h0000_0004);
    occ <= 18'h00031;
    repeat (3) @(posedge sys_clk);
    rd_check(A_ST, 32'h0000_0000);
    $display("test resume done");
    give_verdict;
  end
endmodule : pfr_top_bench

// *** verification/pfr_top_properties.sv ***
// Concurrent checks on the ports of the pause refresh and status block.
// Assumes one AHB-Lite master and the frame request handshake of the top.
`timescale 1ns/1ps
module pfr_top_properties
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Bus side.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Occupancy and frame request.
  input wire logic [17:0] rx_occupancy,
  input wire logic tx_req_valid,
  input wire logic tx_req_resume,
  input wire logic [15:0] tx_req_pause_time,
  input wire logic tx_req_ready
);
  // Data phase markers and shadows of the settings written by software.
  logic dp_rd;
  logic dp_wr;
  logic [15:0] dp_a;
  logic [15:0] ptime_sh;
  logic [15:0] thr_sh;
  logic [13:0] high_sh;
  // Shadows follow the write data at the edge that ends each data phase.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dp_rd <= 1'b0;
      dp_wr <= 1'b0;
      dp_a <= 16'h0000;
      ptime_sh <= 16'h0000;
      thr_sh <= 16'h0000;
      high_sh <= 14'h0000;
    end
    else
    begin
      dp_rd <= hsel && htrans[1] && hready && !hwrite;
      dp_wr <= hsel && htrans[1] && hready && hwrite;
      dp_a <= haddr[15:0];
      if (dp_wr && dp_a == pfr_pkg::OFF_PAUSE_TIME)
        ptime_sh <= hwdata[15:0];
      if (dp_wr && dp_a == pfr_pkg::OFF_REFRESH_THR)
        thr_sh <= hwdata[15:0];
      if (dp_wr && dp_a == pfr_pkg::OFF_HIGH_WM)
        high_sh <= hwdata[17:4];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_ready;
    hreadyout == 1'b1;
  endproperty
  a_ready: assert property (p_ready)
    else $error("hreadyout dropped");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay)
    else $error("hresp not okay");
  property p_hold;
    tx_req_valid && !tx_req_ready |=> tx_req_valid;
  endproperty
  a_hold: assert property (p_hold)
    else $error("request withdrawn before taken");
  property p_xon_time;
    tx_req_valid && tx_req_resume |-> tx_req_pause_time == 16'h0000;
  endproperty
  a_xon_time: assert property (p_xon_time)
    else $error("resume frame with pause time");
  property p_xoff_time;
    tx_req_valid && !tx_req_resume |-> tx_req_pause_time == ptime_sh;
  endproperty
  a_xoff_time: assert property (p_xoff_time)
    else $error("pause frame time differs");
  property p_cnt;
    dp_rd && dp_a == pfr_pkg::OFF_STATUS && !hrdata[0]
      |-> hrdata[31:16] == 16'h0000;
  endproperty
  a_cnt: assert property (p_cnt)
    else $error("counter runs while resumed");
  property p_resv;
    dp_rd && dp_a == pfr_pkg::OFF_STATUS |-> hrdata[15:3] == 13'h0000;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved status bits set");
  property p_unmap;
    dp_rd && dp_a > pfr_pkg::OFF_PAUSE_TIME |-> hrdata == 32'h0000_0000;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  // Without refresh, a new pause frame only follows occupancy at or above the high watermark.
  property p_norefresh;
    $rose(tx_req_valid) && !tx_req_resume && thr_sh == 16'h0000
      |-> $past(rx_occupancy) >= {high_sh, 4'h0};
  endproperty
  a_norefresh: assert property (p_norefresh)
    else $error("pause frame without cause");
  c_xoff: cover property (tx_req_valid && tx_req_ready && !tx_req_resume);
  c_xon: cover property (tx_req_valid && tx_req_ready && tx_req_resume);
  c_state: cover property (dp_rd && dp_a == pfr_pkg::OFF_STATUS && hrdata[0]);
endmodule : pfr_top_properties
bind pfr_top pfr_top_properties u_props (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .rx_occupancy(rx_occupancy),
  .tx_req_valid(tx_req_valid), .tx_req_resume(tx_req_resume),
  .tx_req_pause_time(tx_req_pause_time), .tx_req_ready(tx_req_ready));

// *** verification/pfr_tx_model.sv ***
// Transmitter model that takes pause frame requests and counts frames.
// Assumes the request stands until this model raises ready.
`timescale 1ns/1ps
module pfr_tx_model
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Request and the stall to apply, in cycles.
  input wire logic req_valid,
  input wire logic req_resume,
  input wire logic [15:0] req_time,
  input wire logic [1:0] delay,
  output logic req_ready,
  // Frames sent so far.
  output int xoff_n,
  output int xon_n,
  output logic [15:0] last_time
);
  logic [1:0] wait_n;
  // Ready comes at least one cycle late, as a busy line would make it.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      req_ready <= 1'b0;
      wait_n <= 2'd0;
      xoff_n <= 0;
      xon_n <= 0;
      last_time <= 16'h0000;
    end
    else
    begin
      req_ready <= req_valid && !req_ready && wait_n == delay;
      if (req_valid && !req_ready && wait_n != delay)
        wait_n <= wait_n + 2'd1;
      else
        wait_n <= 2'd0;
      if (req_valid && req_ready && req_resume)
        xon_n <= xon_n + 1;
      if (req_valid && req_ready && !req_resume)
        xoff_n <= xoff_n + 1;
      if (req_valid && req_ready && !req_resume)
        last_time <= req_time;
    end
  end
endmodule : pfr_tx_model
